// File: shared/ccpsd_map.vh
// register offsets, field positions and reset values for the shutdown/dead-time/status block
`ifndef CCPSD_MAP_VH
`define CCPSD_MAP_VH
`define CCPSD_ADDR_W 4
`define CCPSD_OFF_CON3 4'h0
`define CCPSD_OFF_STAT 4'h4
`define CCPSD_OFF_CTRL 4'h8
`define CCPSD_OFF_IFLAG 4'hC
`define CCPSD_OFF_IMASK 4'h0
`define CCPSD_OFF_MASK 4'h0
`define CCPSD_RST_CON3 32'h0000_0000
`define CCPSD_RST_CTRL 32'h0000_0000
`define CCPSD_PSSA_HI 19
`define CCPSD_PSSA_LO 18
`define CCPSD_PSSB_HI 17
`define CCPSD_PSSB_LO 16
`define CCPSD_DT_HI 5
`define CCPSD_DT_LO 0
`define CCPSD_ST_PEND_HI 20
`define CCPSD_ST_PEND_LO 16
`define CCPSD_ST_GARM 10
`define CCPSD_ST_TRIG 7
`define CCPSD_ST_TSET 6
`define CCPSD_ST_TCLR 5
`define CCPSD_ST_SDEV 4
`define CCPSD_ST_SCEV 3
`define CCPSD_ST_CDIS 2
`define CCPSD_ST_COV 1
`define CCPSD_ST_CNE 0
`define CCPSD_CT_TRIGGERED_MODE_ENABLE 0
`define CCPSD_CT_RESTART 1
`define CCPSD_CT_GWAIT 2
`define CCPSD_CT_GMODE_HI 5
`define CCPSD_CT_GMODE_LO 4
`define CCPSD_IRQ_W 3
`define CCPSD_IRQ_SDEV 0
`define CCPSD_IRQ_SCEV 1
`define CCPSD_IRQ_COV 2
`define CCPSD_GM_LEVEL 2'h0
`define CCPSD_GM_RISE 2'h1
`define CCPSD_GM_FALL 2'h2
`define CCPSD_PSS_ACTIVE 2'h3
`define CCPSD_PSS_INACTIVE 2'h2
`endif

// File: rtl/ccpsd_dead_time.v
// dead-time insertion for one complementary output pair
`timescale 1ns/1ps
`default_nettype none
module ccpsd_dead_time #(
	parameter DT_W = 6
) (
	// clock and reset
	input wire sys_clk_in,
	input wire reset_n_in,
	// control
	input wire [DT_W-1:0] dead_time_count_in,
	input wire pwm_in,
	// complementary outputs
	output reg out_p_out,
	output reg out_n_out
);
	reg pwm_q;
	reg [DT_W-1:0] cnt_q;
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pwm_q <= 1'b0;
			cnt_q <= {DT_W{1'b0}};
			out_p_out <= 1'b0;
			out_n_out <= 1'b0;
		end else begin
			pwm_q <= pwm_in;
			if (dead_time_count_in == {DT_W{1'b0}}) begin
				// zero count bypasses the dead-time logic
				cnt_q <= {DT_W{1'b0}};
				out_p_out <= pwm_in;
				out_n_out <= ~pwm_in;
			end else if (pwm_in != pwm_q) begin
				// partner turns off now, newcomer waits N+1 clocks
				cnt_q <= dead_time_count_in;
				out_p_out <= 1'b0;
				out_n_out <= 1'b0;
			end else if (cnt_q != {DT_W{1'b0}}) begin
				cnt_q <= cnt_q - {{(DT_W-1){1'b0}}, 1'b1};
				out_p_out <= 1'b0;
				out_n_out <= 1'b0;
			end else begin
				out_p_out <= pwm_q;
				out_n_out <= ~pwm_q;
			end
		end
	end
endmodule
`default_nettype wire

// File: rtl/ccpsd_pin_group.v
// shutdown drive state for one three-pin output group
`timescale 1ns/1ps
`default_nettype none
`include "ccpsd_map.vh"
module ccpsd_pin_group (
	// clock and reset
	input wire sys_clk_in,
	input wire reset_n_in,
	// control
	input wire shutdown_in,
	input wire polarity_low_in,
	input wire [1:0] shutdown_state_in,
	input wire [2:0] pwm_in,
	// pins
	output reg [2:0] pin_out,
	output reg [2:0] pin_oe_out
);
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_out <= 3'h0;
			pin_oe_out <= 3'h0;
		end else if (!shutdown_in) begin
			pin_out <= pwm_in ^ {3{polarity_low_in}};
			pin_oe_out <= 3'h7;
		end else if (shutdown_state_in == `CCPSD_PSS_ACTIVE) begin
			pin_out <= {3{~polarity_low_in}};
			pin_oe_out <= 3'h7;
		end else if (shutdown_state_in == `CCPSD_PSS_INACTIVE) begin
			pin_out <= {3{polarity_low_in}};
			pin_oe_out <= 3'h7;
		end else begin
			// 0x: release the pins
			pin_out <= 3'h0;
			pin_oe_out <= 3'h0;
		end
	end
endmodule
`default_nettype wire

// File: rtl/ccpsd_top.v
// shutdown states, dead time and status register of the capture/compare/PWM unit
// Behaviour
// - group A shutdown: 11 active, 10 inactive, 0x tristate
// - group B shutdown uses the same encoding
// - six-bit dead time, N periods (code holds both outputs off N+1 clocks), zero disables
// - dead time, group B state only multi-output
// - bits 20..16 flag pending buffered updates
// - gate arm write arms one-shot, reads zero
// - trigger bit shows timer triggered and running
// - trigger-set write triggers when triggered mode
// - trigger-clear write cancels when triggered mode
// - shutdown flag high while shutdown, software clearable
// - single-edge compare flag sticky until cleared
// - capture disable blocks capture events
// - capture overflow flag sticky until cleared
// - not-empty flag mirrors capture buffer data
// - unimplemented status bits read zero
// - auto-restart clears shutdown flag next period
// - gate wait delays shutdown to period boundary
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ccpsd_map.vh"
module ccpsd_top #(
	parameter MULTI_OUTPUT = 1,
	parameter DT_W = 6
) (
	// clock and reset
	input wire sys_clk_in,
	input wire reset_n_in,
	// register port
	input wire [`CCPSD_ADDR_W-1:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_write_in,
	input wire reg_read_in,
	output reg [31:0] reg_rdata_out,
	// interrupt
	output wire irq_out,
	// events from the rest of the unit
	input wire shutdown_request_in,
	input wire period_boundary_in,
	input wire hw_trigger_in,
	input wire single_compare_in,
	input wire capture_overflow_in,
	input wire capture_not_empty_in,
	input wire gate_source_in,
	input wire capture_edge_in,
	input wire [4:0] update_pending_in,
	input wire [2:0] pwm_a_in,
	input wire [2:0] pwm_b_in,
	input wire polarity_a_low_in,
	input wire polarity_b_low_in,
	// outputs to the rest of the unit
	output wire capture_event_out,
	output reg trigger_active_out,
	output wire shutdown_active_out,
	// pin groups A (A,C,E) and B (B,D,F)
	output wire [2:0] group_a_pin_out,
	output wire [2:0] group_a_oe_out,
	output wire [2:0] group_b_pin_out,
	output wire [2:0] group_b_oe_out
);
	reg [1:0] shutdown_state_group_a_q;
	reg [1:0] shutdown_state_group_b_q;
	reg [DT_W-1:0] dead_time_count_q;
	reg triggered_mode_enable_q;
	reg auto_restart_enable_q;
	reg shutdown_gate_wait_q;
	reg [1:0] capture_gate_mode_q;
	reg shutdown_event_flag_q;
	reg single_compare_event_flag_q;
	reg capture_overflow_flag_q;
	reg capture_disable_q;
	reg gate_armed_q;
	reg gate_src_q;
	reg sd_pending_q;
	reg sd_input_seen_q;
	reg [`CCPSD_IRQ_W-1:0] irq_flag_q;
	reg [`CCPSD_IRQ_W-1:0] irq_mask_q;
	reg [31:0] rdata_d;
	wire wr_con3 = reg_write_in && (reg_addr_in == `CCPSD_OFF_CON3);
	wire wr_stat = reg_write_in && (reg_addr_in == `CCPSD_OFF_STAT);
	wire wr_ctrl = reg_write_in && (reg_addr_in == `CCPSD_OFF_CTRL);
	wire wr_iflag = reg_write_in && (reg_addr_in == `CCPSD_OFF_IFLAG);
	// the interrupt mask lives in the control register, so it has no write decode of its own
	// status clears: a written zero clears, a written one leaves it
	wire clr_sdev = wr_stat && !reg_wdata_in[`CCPSD_ST_SDEV];
	wire clr_scev = wr_stat && !reg_wdata_in[`CCPSD_ST_SCEV];
	wire clr_cov = wr_stat && !reg_wdata_in[`CCPSD_ST_COV];
	wire clr_cdis = wr_stat && !reg_wdata_in[`CCPSD_ST_CDIS];
	wire tset = wr_stat && reg_wdata_in[`CCPSD_ST_TSET] && triggered_mode_enable_q;
	wire tclr = wr_stat && reg_wdata_in[`CCPSD_ST_TCLR] && triggered_mode_enable_q;
	wire garm = wr_stat && reg_wdata_in[`CCPSD_ST_GARM] &&
		((capture_gate_mode_q == `CCPSD_GM_RISE) || (capture_gate_mode_q == `CCPSD_GM_FALL));
	wire gate_rise = gate_source_in && !gate_src_q;
	wire gate_fall = !gate_source_in && gate_src_q;
	// shutdown starts now, or at the boundary when gate wait is set
	wire sd_start = shutdown_request_in && (!shutdown_gate_wait_q || period_boundary_in);
	// capture edges suppressed while disabled
	assign capture_event_out = capture_edge_in && !capture_disable_q;
	assign shutdown_active_out = shutdown_event_flag_q;
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			shutdown_state_group_a_q <= 2'h0;
			shutdown_state_group_b_q <= 2'h0;
			dead_time_count_q <= {DT_W{1'b0}};
			triggered_mode_enable_q <= 1'b0;
			auto_restart_enable_q <= 1'b0;
			shutdown_gate_wait_q <= 1'b0;
			capture_gate_mode_q <= 2'h0;
			irq_mask_q <= {`CCPSD_IRQ_W{1'b0}};
		end else begin
			if (wr_con3) begin
				shutdown_state_group_a_q <= reg_wdata_in[`CCPSD_PSSA_HI:`CCPSD_PSSA_LO];
				// group B state and dead time absent in single-output variant
				if (MULTI_OUTPUT != 0) begin
					shutdown_state_group_b_q <= reg_wdata_in[`CCPSD_PSSB_HI:`CCPSD_PSSB_LO];
					dead_time_count_q <= reg_wdata_in[DT_W-1:0];
				end
			end
			if (wr_ctrl) begin
				triggered_mode_enable_q <= reg_wdata_in[`CCPSD_CT_TRIGGERED_MODE_ENABLE];
				auto_restart_enable_q <= reg_wdata_in[`CCPSD_CT_RESTART];
				shutdown_gate_wait_q <= reg_wdata_in[`CCPSD_CT_GWAIT];
				capture_gate_mode_q <= reg_wdata_in[`CCPSD_CT_GMODE_HI:`CCPSD_CT_GMODE_LO];
				irq_mask_q <= reg_wdata_in[8+`CCPSD_IRQ_W-1:8];
			end
		end
	end
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			shutdown_event_flag_q <= 1'b0;
			single_compare_event_flag_q <= 1'b0;
			capture_overflow_flag_q <= 1'b0;
			capture_disable_q <= 1'b0;
			gate_armed_q <= 1'b0;
			gate_src_q <= 1'b0;
			trigger_active_out <= 1'b0;
			sd_input_seen_q <= 1'b0;
			sd_pending_q <= 1'b0;
		end else begin
			gate_src_q <= gate_source_in;
			// trigger: set by hardware or set request, cleared by clear request
			if (hw_trigger_in || tset)
				trigger_active_out <= 1'b1;
			else if (tclr)
				trigger_active_out <= 1'b0;
			// shutdown flag, set wins over software clear
			sd_pending_q <= 1'b0;
			if (sd_start)
				shutdown_event_flag_q <= 1'b1;
			else if (clr_sdev)
				shutdown_event_flag_q <= 1'b0;
			else if (auto_restart_enable_q && shutdown_event_flag_q && !shutdown_request_in &&
				period_boundary_in)
				shutdown_event_flag_q <= 1'b0;
			sd_input_seen_q <= shutdown_request_in;
			// sticky compare and overflow flags
			if (single_compare_in)
				single_compare_event_flag_q <= 1'b1;
			else if (clr_scev)
				single_compare_event_flag_q <= 1'b0;
			if (capture_overflow_in)
				capture_overflow_flag_q <= 1'b1;
			else if (clr_cov)
				capture_overflow_flag_q <= 1'b0;
			// capture gating
			if (garm)
				gate_armed_q <= 1'b1;
			if (capture_gate_mode_q == `CCPSD_GM_LEVEL) begin
				capture_disable_q <= !gate_source_in;
			end else if (gate_armed_q && (capture_gate_mode_q == `CCPSD_GM_RISE) && gate_rise) begin
				capture_disable_q <= 1'b0;
				gate_armed_q <= 1'b0;
			end else if (gate_armed_q && (capture_gate_mode_q == `CCPSD_GM_FALL) && gate_fall) begin
				capture_disable_q <= 1'b1;
				gate_armed_q <= 1'b0;
			end else if (clr_cdis) begin
				capture_disable_q <= 1'b0;
			end
		end
	end
	// interrupt flags: events set, writing one clears, set wins
	wire [`CCPSD_IRQ_W-1:0] irq_evt = {capture_overflow_in, single_compare_in, sd_start};
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			irq_flag_q <= {`CCPSD_IRQ_W{1'b0}};
		else
			irq_flag_q <= irq_evt | (irq_flag_q & ~(wr_iflag ? reg_wdata_in[`CCPSD_IRQ_W-1:0] :
				{`CCPSD_IRQ_W{1'b0}}));
	end
	assign irq_out = |(irq_flag_q & irq_mask_q);
	// read mux; unlisted status bits and request bits read zero
	always @* begin
		rdata_d = 32'h0000_0000;
		case (reg_addr_in)
			`CCPSD_OFF_CON3: begin
				rdata_d[`CCPSD_PSSA_HI:`CCPSD_PSSA_LO] = shutdown_state_group_a_q;
				rdata_d[`CCPSD_PSSB_HI:`CCPSD_PSSB_LO] = shutdown_state_group_b_q;
				rdata_d[DT_W-1:0] = dead_time_count_q;
			end
			`CCPSD_OFF_STAT: begin
				rdata_d[`CCPSD_ST_PEND_HI:`CCPSD_ST_PEND_LO] = update_pending_in;
				rdata_d[`CCPSD_ST_TRIG] = trigger_active_out;
				rdata_d[`CCPSD_ST_SDEV] = shutdown_event_flag_q;
				rdata_d[`CCPSD_ST_SCEV] = single_compare_event_flag_q;
				rdata_d[`CCPSD_ST_CDIS] = capture_disable_q;
				rdata_d[`CCPSD_ST_COV] = capture_overflow_flag_q;
				rdata_d[`CCPSD_ST_CNE] = capture_not_empty_in;
			end
			`CCPSD_OFF_CTRL: begin
				rdata_d[`CCPSD_CT_TRIGGERED_MODE_ENABLE] = triggered_mode_enable_q;
				rdata_d[`CCPSD_CT_RESTART] = auto_restart_enable_q;
				rdata_d[`CCPSD_CT_GWAIT] = shutdown_gate_wait_q;
				rdata_d[`CCPSD_CT_GMODE_HI:`CCPSD_CT_GMODE_LO] = capture_gate_mode_q;
				rdata_d[8+`CCPSD_IRQ_W-1:8] = irq_mask_q;
			end
			`CCPSD_OFF_IFLAG: begin
				rdata_d[`CCPSD_IRQ_W-1:0] = irq_flag_q;
			end
			default: begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			reg_rdata_out <= 32'h0000_0000;
		else if (reg_read_in)
			reg_rdata_out <= rdata_d;
		else
			reg_rdata_out <= 32'h0000_0000;
	end
	// dead time between A-side and B-side of each pair
	wire [2:0] dt_p;
	wire [2:0] dt_n;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_pair
			if (MULTI_OUTPUT != 0) begin : g_dt
				ccpsd_dead_time #(.DT_W(DT_W)) u_dt (
					.sys_clk_in(sys_clk_in),
					.reset_n_in(reset_n_in),
					.dead_time_count_in(dead_time_count_q),
					.pwm_in(pwm_a_in[gi]),
					.out_p_out(dt_p[gi]),
					.out_n_out(dt_n[gi])
				);
			end else begin : g_nodt
				assign dt_p[gi] = pwm_a_in[gi];
				assign dt_n[gi] = pwm_b_in[gi];
			end
		end
	endgenerate
	wire [2:0] pwm_b_sel = (dead_time_count_q == {DT_W{1'b0}}) ? pwm_b_in : dt_n;
	wire [2:0] pwm_a_sel = (dead_time_count_q == {DT_W{1'b0}}) ? pwm_a_in : dt_p;
	// shutdown pin states per group
	ccpsd_pin_group u_grp_a (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.shutdown_in(shutdown_event_flag_q),
		.polarity_low_in(polarity_a_low_in),
		.shutdown_state_in(shutdown_state_group_a_q),
		.pwm_in(pwm_a_sel),
		.pin_out(group_a_pin_out),
		.pin_oe_out(group_a_oe_out)
	);
	ccpsd_pin_group u_grp_b (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.shutdown_in(shutdown_event_flag_q),
		.polarity_low_in(polarity_b_low_in),
		.shutdown_state_in(shutdown_state_group_b_q),
		.pwm_in(pwm_b_sel),
		.pin_out(group_b_pin_out),
		.pin_oe_out(group_b_oe_out)
	);
endmodule
`default_nettype wire

// File: bench/ccpsd_top_assertions.sv
// port assertions for the shutdown/dead-time/status block
`timescale 1ns/1ps
`default_nettype none
module ccpsd_chk (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// register port
	input wire logic [3:0] reg_addr_in,
	input wire logic reg_read_in,
	input wire logic reg_write_in,
	input wire logic [31:0] reg_rdata_out,
	// events and outputs
	input wire logic shutdown_request_in,
	input wire logic period_boundary_in,
	input wire logic hw_trigger_in,
	input wire logic capture_not_empty_in,
	input wire logic capture_edge_in,
	input wire logic [4:0] update_pending_in,
	input wire logic capture_event_out,
	input wire logic trigger_active_out,
	input wire logic shutdown_active_out,
	input wire logic [2:0] group_a_oe_out,
	input wire logic [2:0] group_b_oe_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_stat_rd;
		reg_read_in && reg_addr_in == 4'h4;
	endsequence
	sequence s_sd_held;
		shutdown_active_out [*2];
	endsequence
	property p_idle_rdata;
		!reg_read_in |=> reg_rdata_out == 32'h0000_0000;
	endproperty
	a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside read slot");
	property p_unimpl;
		s_stat_rd |=> (reg_rdata_out & 32'hFFE0_FF60) == 32'h0000_0000;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("status zero bits read set");
	property p_pending;
		s_stat_rd |=> reg_rdata_out[20:16] == $past(update_pending_in);
	endproperty
	a_pending: assert property (p_pending) else $error("pending bits wrong");
	property p_not_empty;
		s_stat_rd |=> reg_rdata_out[0] == $past(capture_not_empty_in);
	endproperty
	a_not_empty: assert property (p_not_empty) else $error("not empty bit wrong");
	property p_cap_event;
		capture_event_out |-> capture_edge_in;
	endproperty
	a_cap_event: assert property (p_cap_event) else $error("capture event without edge");
	property p_trig_rise;
		$rose(trigger_active_out) |-> $past(hw_trigger_in) || $past(reg_write_in);
	endproperty
	a_trig_rise: assert property (p_trig_rise) else $error("trigger set without cause");
	property p_sd_start;
		$rose(shutdown_active_out) |-> $past(shutdown_request_in);
	endproperty
	a_sd_start: assert property (p_sd_start) else $error("shutdown without request");
	property p_sd_stay;
		shutdown_active_out && !reg_write_in && !period_boundary_in |=> shutdown_active_out;
	endproperty
	a_sd_stay: assert property (p_sd_stay) else $error("shutdown flag dropped");
	property p_sd_pins;
		s_sd_held |-> (group_a_oe_out == 3'h0 || group_a_oe_out == 3'h7) && (group_b_oe_out == 3'h0 || group_b_oe_out == 3'h7);
	endproperty
	a_sd_pins: assert property (p_sd_pins) else $error("group pins split in shutdown");
endmodule
bind ccpsd_top ccpsd_chk ccpsd_chk_i (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
	.reg_read_in(reg_read_in), .reg_write_in(reg_write_in), .reg_rdata_out(reg_rdata_out),
	.shutdown_request_in(shutdown_request_in), .period_boundary_in(period_boundary_in), .hw_trigger_in(hw_trigger_in),
	.capture_not_empty_in(capture_not_empty_in), .capture_edge_in(capture_edge_in), .update_pending_in(update_pending_in),
	.capture_event_out(capture_event_out), .trigger_active_out(trigger_active_out),
	.shutdown_active_out(shutdown_active_out), .group_a_oe_out(group_a_oe_out), .group_b_oe_out(group_b_oe_out));
`default_nettype wire

// File: bench/ccpsd_stage_model.sv
// far side: power-stage pin lines and capture input edge source
`timescale 1ns/1ps
`default_nettype none
module ccpsd_stage_model (
	input wire logic sys_clk_in,
	input wire logic [2:0] pin_in,
	input wire logic [2:0] oe_in,
	input wire logic cap_level_in,
	output logic [2:0] line_out,
	output logic cap_edge_out
);
	logic [2:0] last_q = 3'h0;
	logic cap_q = 1'b0;
	// released lines toggle so a stale level is never mistaken for drive
	assign line_out = (pin_in & oe_in) | (~last_q & ~oe_in);
	assign cap_edge_out = cap_level_in & ~cap_q;
	always @(posedge sys_clk_in) begin
		last_q <= line_out;
		cap_q <= cap_level_in;
	end
endmodule
`default_nettype wire

// File: bench/ccpsd_top_tb_top.sv
// self-checking bench for the shutdown/dead-time/status block
`timescale 1ns/1ps
`default_nettype none
module ccpsd_top_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sd_req = 1'b0, bnd = 1'b0, hwt = 1'b0;
	logic scmp = 1'b0, cov = 1'b0, cne = 1'b0, gsrc = 1'b0, caplv = 1'b0, cap_edge, irq, cap_ev, trig, sd;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, r, seed = 32'hC5A2DED3;
	logic [4:0] pend = 5'h0;
	logic [5:0] dt;
	logic [1:0] m;
	logic [2:0] pwm_a = 3'h0, a_pin, a_oe, b_pin, b_oe, a_line;
	int miscompares = 0, cmp_count = 0, n, k;
	always #20 clk = ~clk;
	ccpsd_top ccpsd_top_i (.sys_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata), .irq_out(irq), .shutdown_request_in(sd_req),
		.period_boundary_in(bnd), .hw_trigger_in(hwt), .single_compare_in(scmp), .capture_overflow_in(cov),
		.capture_not_empty_in(cne), .gate_source_in(gsrc), .capture_edge_in(cap_edge), .update_pending_in(pend),
		.pwm_a_in(pwm_a), .pwm_b_in(3'h0), .polarity_a_low_in(1'b0), .polarity_b_low_in(1'b0),
		.capture_event_out(cap_ev), .trigger_active_out(trig), .shutdown_active_out(sd),
		.group_a_pin_out(a_pin), .group_a_oe_out(a_oe), .group_b_pin_out(b_pin), .group_b_oe_out(b_oe));
	ccpsd_stage_model ccpsd_stage_model_i (.sys_clk_in(clk), .pin_in(a_pin), .oe_in(a_oe), .cap_level_in(caplv),
		.line_out(a_line), .cap_edge_out(cap_edge));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		r = rdata;
	endtask
	task automatic edges(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		edges(20000);
		miscompares++;
		end_of_test();
	end
	initial begin
		edges(2);
		rst_n <= 1'b1;
		rreg(4'h0);
		chk("control3 reset", 32'h0, r);
		rreg(4'h2);
		chk("unmapped", 32'h0, r);
		for (n = 0; n < 8; n++) begin
			seed = xs(seed);
			pend <= seed[4:0];
			cne <= seed[5];
			rreg(4'h4);
			chk("pending", seed[4:0], r[20:16]);
			chk("not empty", seed[5], r[0]);
			chk("unimplemented", 32'h0, r & 32'hFFE0_FF60);
		end
		wreg(4'h4, 32'h5E);
		@(negedge clk) chk("set ignored", 1'b0, trig);
		wreg(4'h8, 32'h1);
		wreg(4'h4, 32'h5E);
		rreg(4'h4);
		chk("trigger set", 2'h2, r[7:6]);
		wreg(4'h4, 32'h3E);
		rreg(4'h4);
		chk("trigger clear", 3'h0, r[7:5]);
		@(posedge clk) hwt <= 1'b1;
		@(posedge clk) hwt <= 1'b0;
		@(negedge clk) chk("hw trigger", 1'b1, trig);
		for (k = 0; k < 2; k++) begin
			wreg(4'h8, k ? 32'h0 : 32'h200);
			@(posedge clk);
			scmp <= !k;
			cov <= k;
			@(posedge clk);
			scmp <= 1'b0;
			cov <= 1'b0;
			wreg(4'h4, 32'h1E);
			rreg(4'h4);
			chk("flag kept", 1'b1, r[3 - 2 * k]);
			chk("irq masked", !k, irq);
			wreg(4'h4, k ? 32'h1C : 32'h16);
			rreg(4'h4);
			chk("flag cleared", 1'b0, r[3 - 2 * k]);
			wreg(4'hC, 32'h7);
			@(negedge clk) chk("irq cleared", 1'b0, irq);
		end
		wreg(4'h8, 32'h0);
		@(posedge clk) sd_req <= 1'b1;
		edges(3);
		@(negedge clk) chk("shutdown flag", 1'b1, sd);
		for (k = 0; k < 4; k++) begin
			m = 2'(3 - k);
			wreg(4'h0, {12'h0, m, m, 16'h0});
			edges(1);
			@(negedge clk);
			chk("a oe", {3{m[1]}}, a_oe);
			chk("a pin", {3{m == 2'h3}}, a_pin);
			chk("b oe", {3{m[1]}}, b_oe);
			chk("b pin", {3{m == 2'h3}}, b_pin);
			if (m[1])
				chk("a line", a_pin, a_line);
		end
		sd_req <= 1'b0;
		wreg(4'h4, 32'h0E);
		@(negedge clk) chk("shutdown sw clear", 1'b0, sd);
		wreg(4'h8, 32'h4);
		@(posedge clk) sd_req <= 1'b1;
		edges(4);
		@(negedge clk) chk("gate wait hold", 1'b0, sd);
		@(posedge clk) bnd <= 1'b1;
		@(posedge clk) bnd <= 1'b0;
		@(negedge clk) chk("gate wait boundary", 1'b1, sd);
		wreg(4'h8, 32'h6);
		sd_req <= 1'b0;
		edges(2);
		@(negedge clk) chk("restart waits", 1'b1, sd);
		@(posedge clk) bnd <= 1'b1;
		@(posedge clk) bnd <= 1'b0;
		@(negedge clk) chk("restart clears", 1'b0, sd);
		wreg(4'h8, 32'h0);
		for (k = 0; k < 3; k++) begin
			seed = xs(seed);
			dt = (k == 0) ? 6'h5 : {3'h0, seed[2:0]} + 6'h1;
			wreg(4'h0, {26'h0, dt});
			pwm_a <= 3'h0;
			edges(16);
			pwm_a <= 3'h7;
			n = 0;
			repeat (20) begin
				@(negedge clk);
				if (a_pin === 3'h0 && b_pin === 3'h0)
					n++;
			end
			chk("dead cycles", dt + 6'h1, n[5:0]);
			chk("pair after", 6'h38, {a_pin, b_pin});
		end
		wreg(4'h0, 32'h0);
		@(posedge clk) pwm_a <= 3'h5;
		edges(1);
		@(negedge clk) chk("no dead time", 6'h28, {a_pin, b_pin});
		@(posedge clk) caplv <= 1'b0;
		edges(3);
		caplv <= 1'b1;
		@(negedge clk) chk("capture blocked", 1'b0, cap_ev);
		@(posedge clk) gsrc <= 1'b1;
		caplv <= 1'b0;
		edges(3);
		caplv <= 1'b1;
		@(negedge clk) chk("capture passes", 1'b1, cap_ev);
		@(posedge clk) gsrc <= 1'b0;
		edges(3);
		for (k = 0; k < 2; k++) begin
			wreg(4'h8, (k + 1) << 4);
			wreg(4'h4, 32'h41E);
			@(posedge clk) gsrc <= !k;
			edges(3);
			rreg(4'h4);
			chk("gate one shot", k, r[2]);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
